// file: tb_volume_ramp_auto_mute_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module tb_volume_ramp_auto_mute_ctrl
    import vrm_pkg::*;
    ;
    // ----------------------------------------------------------
    // Stimulus and design outputs
    // ----------------------------------------------------------
    logic       mclk_i, sys_rst_i, clk_en_i, reg_wr_i, reg_rd_i, fs_tick_i;
    logic [7:0] reg_addr_i, reg_wdata_i, shared_volume_code_i;
    logic       soft_mute_i, emerg_mute_i, left_zero_i, right_zero_i;
    logic [2:0] left_zero_run_length_i, right_zero_run_length_i;
    logic [7:0] reg_rdata_o, gain_code_o;
    logic       gain_muted_o, ramp_busy_o, left_mute_o, right_mute_o;
    int         bad_count = 0;              // Mismatches
    int         n_tests   = 0;              // Comparisons
    int         cyc       = 0;              // Cycle counter for timeout
    int         seed;                       // Seed return value
    // Model state: gain, registers, read data, divider, zero runs
    logic [7:0] m_gain, m_rd, goal, cfg;
    logic [7:0] rg [3];
    logic [1:0] rate, stp;
    logic       q [2], m_mute [2], z [2];
    int         dv, n, sz, g, idx;
    int         cnt [2];

    vrm_volume_ramp DUT (.*);

    // ----------------------------------------------------------
    // Clock, clock enable and sample tick
    // ----------------------------------------------------------
    initial begin
        mclk_i = 1'b0;
        forever #4 mclk_i = ~mclk_i;
    end
    // Enable drops one cycle in eight, so frozen edges get exercised
    always @(posedge mclk_i) begin
        #1;
        clk_en_i  = ($urandom % 8) != 0;
        fs_tick_i = ~fs_tick_i;
    end

    // ----------------------------------------------------------
    // Compare tasks and closing report
    // ----------------------------------------------------------
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %0t: byte got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %0t: flag got %b expected %b", $time, got, exp);
        end
    endtask
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // ----------------------------------------------------------
    // Reference model, checked at every edge out of reset before it moves on
    // ----------------------------------------------------------
    always @(posedge mclk_i) begin
        goal = (soft_mute_i | emerg_mute_i) ? VOL_MUTE : shared_volume_code_i;
        if (!sys_rst_i) begin
            chk8(gain_code_o, m_gain);
            chk1(gain_muted_o, m_gain == VOL_MUTE);
            chk1(ramp_busy_o, m_gain != goal);
            chk1(left_mute_o, m_mute[0]);
            chk1(right_mute_o, m_mute[1]);
            chk8(reg_rdata_o, m_rd);
        end
        if (sys_rst_i) begin
            m_gain = VOL_MUTE;
            m_rd   = 8'h00;
            rg     = '{RST_NORMAL_RAMP, RST_EMERGENCY_RAMP, RST_ZERO_MUTE_CFG};
            dv     = 0;
            cnt    = '{0, 0};
            q      = '{1'b0, 1'b0};
            m_mute = '{1'b0, 1'b0};
        end else if (clk_en_i) begin
            // Down uses emergency settings while the fault input is up
            cfg  = emerg_mute_i ? rg[1] : rg[0];
            rate = (goal > m_gain) ? cfg[7:6] : rg[0][3:2];
            stp  = (goal > m_gain) ? cfg[5:4] : rg[0][1:0];
            n    = (rate == 2'h0) ? 1 : (rate == 2'h1) ? 2 : 4;
            sz   = 8 >> stp;
            if (m_gain == goal) begin
                dv = 0;
            end else if (rate == 2'h3) begin
                m_gain = goal;
            end else if (fs_tick_i) begin
                if (dv == n - 1) begin
                    g      = (goal > m_gain) ? m_gain + sz : m_gain - sz;
                    g      = (goal > m_gain) ? ((g > goal) ? goal : g)
                                             : ((g < goal) ? goal : g);
                    m_gain = 8'(g);
                    dv     = 0;
                end else begin
                    dv++;
                end
            end
            // Mute flags follow last cycle's qualify state
            m_mute[0] = rg[2][2] ? (q[0] & q[1] & rg[2][0] & rg[2][1]) : (q[0] & rg[2][0]);
            m_mute[1] = rg[2][2] ? (q[0] & q[1] & rg[2][0] & rg[2][1]) : (q[1] & rg[2][1]);
            z = '{left_zero_i, right_zero_i};
            for (int c = 0; c < 2; c++) begin
                if (!rg[2][c]) begin
                    cnt[c] = 0;
                    q[c]   = 1'b0;
                end else if (fs_tick_i && z[c]) begin
                    cnt[c]++;
                    q[c] = cnt[c] >= 1104;
                end else if (fs_tick_i) begin
                    cnt[c] = 0;
                    q[c]   = 1'b0;
                end
            end
            // Register port: read sees the value before a same-edge write
            idx = int'(reg_addr_i) - 8'h4e;
            if (reg_rd_i) begin
                m_rd = (idx >= 0 && idx < 3) ? rg[idx] : 8'h00;
            end
            if (reg_wr_i && idx >= 0 && idx < 3) begin
                rg[idx] = reg_wdata_i;
            end
        end
        cyc++;
        if (cyc == 80000) begin
            bad_count++;
            $display("BAD %0t: run did not finish in time", $time);
            conclude();
        end
    end

    // ----------------------------------------------------------
    // Bus and pacing tasks
    // ----------------------------------------------------------
    task automatic step();
        @(posedge mclk_i);
        #1;
    endtask
    // Strobe is held until an edge with the clock enable high takes it
    task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
        reg_wr_i    = wr;
        reg_rd_i    = ~wr;
        reg_addr_i  = a;
        reg_wdata_i = d;
        do @(posedge mclk_i); while (clk_en_i !== 1'b1);
        #1;
        reg_wr_i = 1'b0;
        reg_rd_i = 1'b0;
        // One edge passes so a following call never re-raises in this step
        step();
    endtask
    task automatic idle();
        for (int k = 0; k < 3000 && ramp_busy_o !== 1'b0; k++) step();
        step();
    endtask
    task automatic read_all();
        for (int a = 8'h4d; a <= 8'h51; a++) bus(1'b0, 8'(a), 8'h00);
    endtask

    // ----------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------
    initial begin
        {reg_wr_i, reg_rd_i, reg_addr_i, reg_wdata_i} = '0;
        {soft_mute_i, emerg_mute_i, left_zero_i, right_zero_i} = '0;
        {left_zero_run_length_i, right_zero_run_length_i} = '0;
        clk_en_i = 1'b1;
        fs_tick_i = 1'b0;
        shared_volume_code_i = VOL_ZERO_DB;
        sys_rst_i = 1'b1;
        seed = $urandom(6);
        repeat (20) step();
        sys_rst_i = 1'b0;
        // Reset values, unmapped neighbours, random write and read back
        read_all();
        for (int a = 8'h4e; a <= 8'h50; a++) bus(1'b1, 8'(a), 8'($urandom));
        read_all();
        bus(1'b1, OFS_ZERO_MUTE_CFG, 8'h00);
        // Every normal rate and step pair, both directions, one reversal
        for (int i = 0; i < 16; i++) begin
            bus(1'b1, OFS_NORMAL_RAMP, {i[3:2], i[1:0], i[3:2], i[1:0]});
            shared_volume_code_i = 8'($urandom % 255);
            soft_mute_i = 1'b0;
            idle();
            soft_mute_i = 1'b1;
            repeat ($urandom % 40) step();
            soft_mute_i = 1'b0;
            idle();
            soft_mute_i = 1'b1;
            idle();
        end
        // Emergency settings, sometimes together with a soft mute
        bus(1'b1, OFS_NORMAL_RAMP, 8'h33);
        for (int i = 0; i < 16; i++) begin
            bus(1'b1, OFS_EMERGENCY_RAMP, {i[3:0], 4'h5});
            {soft_mute_i, emerg_mute_i} = 2'b00;
            shared_volume_code_i = 8'($urandom % 255);
            idle();
            emerg_mute_i = 1'b1;
            soft_mute_i  = 1'($urandom);
            idle();
        end
        {soft_mute_i, emerg_mute_i} = 2'b00;
        // Zero runs under every enable and coupling setting
        for (int i = 0; i < 8; i++) begin
            bus(1'b1, OFS_ZERO_MUTE_CFG, {5'h00, i[2:0]});
            {left_zero_i, right_zero_i} = 2'b11;
            repeat (2600) step();
            right_zero_i = 1'b0;
            repeat (40) step();
            left_zero_i = 1'b0;
            repeat (10) step();
        end
        // Second reset in mid-run restores the register defaults
        sys_rst_i = 1'b1;
        repeat (2) step();
        sys_rst_i = 1'b0;
        read_all();
        repeat (4) step();
        conclude();
    end
endmodule
`default_nettype wire

// file: vrm_pkg.sv
package vrm_pkg;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_NORMAL_RAMP    = 8'h4e; // volume_normal_ramp
    localparam logic [7:0] OFS_EMERGENCY_RAMP = 8'h4f; // volume_emergency_ramp
    localparam logic [7:0] OFS_ZERO_MUTE_CFG  = 8'h50; // zero_detect_mute_config

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] RST_NORMAL_RAMP    = 8'h33;
    localparam logic [7:0] RST_EMERGENCY_RAMP = 8'h30;
    localparam logic [7:0] RST_ZERO_MUTE_CFG  = 8'h07;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int DOWN_RATE_LSB = 6; // Normal and emergency down rate
    localparam int DOWN_STEP_LSB = 4; // Normal and emergency down step
    localparam int UP_RATE_LSB   = 2; // Normal up rate
    localparam int UP_STEP_LSB   = 0; // Normal up step
    localparam int COUPLE_BIT    = 2; // Mute both only when both qualify
    localparam int RIGHT_EN_BIT  = 1; // Right auto-mute enable
    localparam int LEFT_EN_BIT   = 0; // Left auto-mute enable

    // ------------------------------------------------------------
    // Volume code and timing
    // ------------------------------------------------------------
    localparam logic [7:0] VOL_MUTE     = 8'hff; // Code meaning mute
    localparam logic [7:0] VOL_ZERO_DB  = 8'h30; // 0 dB, 0.5 dB per count
    localparam logic [1:0] RATE_INSTANT = 2'h3;  // Rate code for a jump
    localparam int         RUN_W        = 19;    // Zero-run counter width

    // Sample periods per update, minus one
    function automatic logic [1:0] rate_last(input logic [1:0] rate);
        case (rate)
            2'h0:    rate_last = 2'h0;
            2'h1:    rate_last = 2'h1;
            default: rate_last = 2'h3;
        endcase
    endfunction

    // Step size in half-dB counts: 4, 2, 1, 0.5 dB
    function automatic logic [7:0] step_counts(input logic [1:0] sel);
        case (sel)
            2'h0:    step_counts = 8'h08;
            2'h1:    step_counts = 8'h04;
            2'h2:    step_counts = 8'h02;
            default: step_counts = 8'h01;
        endcase
    endfunction

    // Zero samples needed before auto-mute; counted in samples so it
    // scales with the sample rate by itself
    function automatic logic [RUN_W-1:0] zero_run_limit(input logic [2:0] sel);
        case (sel)
            3'h0:    zero_run_limit = 19'h00450; // 11.5 ms at 96 kHz
            3'h1:    zero_run_limit = 19'h013e0; // 53 ms
            3'h2:    zero_run_limit = 19'h027f0; // 106.5 ms
            3'h3:    zero_run_limit = 19'h063f0; // 266.5 ms
            3'h4:    zero_run_limit = 19'h0c8a0; // 0.535 s
            3'h5:    zero_run_limit = 19'h18f60; // 1.065 s
            3'h6:    zero_run_limit = 19'h3e760; // 2.665 s
            default: zero_run_limit = 19'h7cec0; // 5.33 s
        endcase
    endfunction

endpackage

// file: vrm_volume_ramp.sv
`timescale 1ns/1ps
`default_nettype none
module vrm_volume_ramp
    import vrm_pkg::*;
(
    input  wire logic       mclk_i,
    input  wire logic       sys_rst_i,
    input  wire logic       clk_en_i,
    input  wire logic       reg_wr_i,               // Register write strobe
    input  wire logic       reg_rd_i,               // Register read strobe
    input  wire logic [7:0] reg_addr_i,             // Register offset
    input  wire logic [7:0] reg_wdata_i,            // Write data
    output logic      [7:0] reg_rdata_o,            // Read data, registered
    input  wire logic       fs_tick_i,              // One pulse per sample
    input  wire logic [7:0] shared_volume_code_i,   // Target volume code
    input  wire logic       soft_mute_i,            // Normal mute request
    input  wire logic       emerg_mute_i,           // Clock error or power loss
    input  wire logic       left_zero_i,            // Left sample is zero
    input  wire logic       right_zero_i,           // Right sample is zero
    input  wire logic [2:0] left_zero_run_length_i, // Left run select
    input  wire logic [2:0] right_zero_run_length_i,// Right run select
    output logic      [7:0] gain_code_o,            // Applied volume code
    output logic            gain_muted_o,           // Applied code is mute
    output logic            ramp_busy_o,            // Gain not at goal
    output logic            left_mute_o,            // Left auto-muted
    output logic            right_mute_o            // Right auto-muted
);

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [7:0] normal_ramp_ff;  // volume_normal_ramp
    logic [7:0] emerg_ramp_ff;   // volume_emergency_ramp
    logic [7:0] mute_cfg_ff;     // zero_detect_mute_config
    logic [7:0] rdata_ff;        // Read data holding register

    // Writes store whole bytes; reserved bits read back as written
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            normal_ramp_ff <= RST_NORMAL_RAMP;
            emerg_ramp_ff  <= RST_EMERGENCY_RAMP;
            mute_cfg_ff    <= RST_ZERO_MUTE_CFG;
        end else if (clk_en_i && reg_wr_i) begin
            case (reg_addr_i)
                OFS_NORMAL_RAMP:    normal_ramp_ff <= reg_wdata_i;
                OFS_EMERGENCY_RAMP: emerg_ramp_ff  <= reg_wdata_i;
                OFS_ZERO_MUTE_CFG:  mute_cfg_ff    <= reg_wdata_i;
                default: begin
                    // Unmapped offsets are ignored
                end
            endcase
        end
    end

    // Read mux; unmapped offsets read as zero
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            rdata_ff <= 8'h00;
        end else if (clk_en_i && reg_rd_i) begin
            case (reg_addr_i)
                OFS_NORMAL_RAMP:    rdata_ff <= normal_ramp_ff;
                OFS_EMERGENCY_RAMP: rdata_ff <= emerg_ramp_ff;
                OFS_ZERO_MUTE_CFG:  rdata_ff <= mute_cfg_ff;
                default:            rdata_ff <= 8'h00;
            endcase
        end
    end

    assign reg_rdata_o = rdata_ff;

    // ------------------------------------------------------------
    // Field decode
    // ------------------------------------------------------------
    logic [1:0] soft_down_rate;       // Normal down rate
    logic [1:0] soft_down_increment;  // Normal down step
    logic [1:0] soft_up_rate;         // Normal up rate
    logic [1:0] soft_up_increment;    // Normal up step
    logic [1:0] fast_down_rate;       // Emergency down rate
    logic [1:0] fast_down_increment;  // Emergency down step

    assign soft_down_rate      = normal_ramp_ff[DOWN_RATE_LSB +: 2];
    assign soft_down_increment = normal_ramp_ff[DOWN_STEP_LSB +: 2];
    assign soft_up_rate        = normal_ramp_ff[UP_RATE_LSB +: 2];
    assign soft_up_increment   = normal_ramp_ff[UP_STEP_LSB +: 2];
    assign fast_down_rate      = emerg_ramp_ff[DOWN_RATE_LSB +: 2];
    assign fast_down_increment = emerg_ramp_ff[DOWN_STEP_LSB +: 2];

    // ------------------------------------------------------------
    // Ramp control
    // ------------------------------------------------------------
    logic [7:0] gain_code_ff; // Applied code, larger is quieter
    logic [1:0] div_cnt_ff;   // Sample periods since last update
    logic [7:0] goal;         // Code the gain heads for
    logic       go_down;      // Gain must get quieter
    logic       go_up;        // Gain must get louder
    logic [1:0] rate;         // Active rate code
    logic [7:0] step_n;       // Active step in half-dB counts
    logic       instant;      // Jump this cycle
    logic       upd;          // Step this cycle
    logic       clamp;        // Step would reach or pass goal
    logic [8:0] sum_down;     // Wide sum avoids wrap past mute
    logic [7:0] nxt_gain;     // Gain after a step

    // Select goal, direction and settings
    always_comb begin
        goal    = (emerg_mute_i || soft_mute_i) ? VOL_MUTE : shared_volume_code_i;
        go_down = goal > gain_code_ff;
        go_up   = goal < gain_code_ff;
        if (emerg_mute_i) begin
            rate   = fast_down_rate;
            step_n = step_counts(fast_down_increment);
        end else if (go_down) begin
            rate   = soft_down_rate;
            step_n = step_counts(soft_down_increment);
        end else begin
            rate   = soft_up_rate;
            step_n = step_counts(soft_up_increment);
        end
    end

    assign instant = clk_en_i && (go_down || go_up) && (rate == RATE_INSTANT);

    assign upd = clk_en_i && fs_tick_i && (go_down || go_up)
                 && (rate != RATE_INSTANT) && (div_cnt_ff == rate_last(rate));

    assign sum_down = {1'b0, gain_code_ff} + {1'b0, step_n};
    always_comb begin
        if (go_down) begin
            clamp    = sum_down >= {1'b0, goal};
            nxt_gain = clamp ? goal : sum_down[7:0];
        end else begin
            // Nine-bit sum so a goal near mute cannot wrap and overshoot
            clamp    = {1'b0, gain_code_ff} <= ({1'b0, goal} + {1'b0, step_n});
            nxt_gain = clamp ? goal : 8'(gain_code_ff - step_n);
        end
    end

    // Gain register; power-up starts muted and ramps to target
    // step down
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            gain_code_ff <= VOL_MUTE;
        end else if (instant) begin
            gain_code_ff <= goal;
        end else if (upd) begin
            gain_code_ff <= nxt_gain;
        end
    end

    // Sample divider restarts after each update or when idle, so a new
    // ramp from idle waits a full period before its first step; a reversal keeps the count
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            div_cnt_ff <= 2'h0;
        end else if (clk_en_i) begin
            if (!(go_down || go_up) || upd || instant) begin
                div_cnt_ff <= 2'h0;
            end else if (fs_tick_i) begin
                div_cnt_ff <= 2'(div_cnt_ff + 1'b1);
            end
        end
    end

    assign gain_code_o  = gain_code_ff;
    assign gain_muted_o = (gain_code_ff == VOL_MUTE);
    assign ramp_busy_o  = go_down || go_up;

    // ------------------------------------------------------------
    // Auto-mute
    // ------------------------------------------------------------
    logic left_qual;     // Left run complete
    logic right_qual;    // Right run complete
    logic left_mute_ff;  // Left mute output
    logic right_mute_ff; // Right mute output

    vrm_zero_run u_left (
        .mclk_i        (mclk_i),
        .sys_rst_i     (sys_rst_i),
        .clk_en_i      (clk_en_i),
        .sample_stb_i  (fs_tick_i),
        .sample_zero_i (left_zero_i),
        .enable_i      (mute_cfg_ff[LEFT_EN_BIT]),
        .run_sel_i     (left_zero_run_length_i),
        .qualify_o     (left_qual)
    );

    vrm_zero_run u_right (
        .mclk_i        (mclk_i),
        .sys_rst_i     (sys_rst_i),
        .clk_en_i      (clk_en_i),
        .sample_stb_i  (fs_tick_i),
        .sample_zero_i (right_zero_i),
        .enable_i      (mute_cfg_ff[RIGHT_EN_BIT]),
        .run_sel_i     (right_zero_run_length_i),
        .qualify_o     (right_qual)
    );

    // Coupled mode needs both channels; with one disabled, neither mutes
    // channel coupling
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            left_mute_ff  <= 1'b0;
            right_mute_ff <= 1'b0;
        end else if (clk_en_i) begin
            if (mute_cfg_ff[COUPLE_BIT]) begin
                // Enables gate too: a qualify lingers one cycle after a disable
                left_mute_ff  <= left_qual && right_qual
                                 && mute_cfg_ff[LEFT_EN_BIT] && mute_cfg_ff[RIGHT_EN_BIT];
                right_mute_ff <= left_qual && right_qual
                                 && mute_cfg_ff[LEFT_EN_BIT] && mute_cfg_ff[RIGHT_EN_BIT];
            end else begin
                left_mute_ff  <= left_qual && mute_cfg_ff[LEFT_EN_BIT];
                right_mute_ff <= right_qual && mute_cfg_ff[RIGHT_EN_BIT];
            end
        end
    end

    assign left_mute_o  = left_mute_ff;
    assign right_mute_o = right_mute_ff;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (sys_rst_i);

    sequence s_soft_down_step;
        upd && go_down && !emerg_mute_i && !clamp;
    endsequence
    sequence s_up_step;
        upd && go_up && !emerg_mute_i && !clamp;
    endsequence

    property p_down_slow;
        (upd && go_down && !emerg_mute_i && soft_down_rate == 2'h2) |=> !upd [*3];
    endproperty
    a_down_slow: assert property (p_down_slow)
        else $error("Soft down update came before four samples");

    property p_down_step;
        s_soft_down_step |=> gain_code_ff == 8'($past(gain_code_ff) + $past(step_n));
    endproperty
    a_down_step: assert property (p_down_step)
        else $error("Soft down step size wrong");

    property p_down_instant;
        (instant && go_down && !emerg_mute_i) |=> gain_code_ff == $past(goal);
    endproperty
    a_down_instant: assert property (p_down_instant)
        else $error("Instant down did not reach goal");

    property p_up_pace;
        (upd && go_up && !emerg_mute_i && soft_up_rate == 2'h1) |=> !upd;
    endproperty
    a_up_pace: assert property (p_up_pace)
        else $error("Up update came before two samples");

    property p_up_instant;
        (instant && go_up) |=> gain_code_ff == $past(shared_volume_code_i);
    endproperty
    a_up_instant: assert property (p_up_instant)
        else $error("Instant unmute did not restore volume");

    property p_up_step;
        s_up_step |=> gain_code_ff == 8'($past(gain_code_ff) - $past(step_n));
    endproperty
    a_up_step: assert property (p_up_step)
        else $error("Up step size wrong");

    property p_emerg_step;
        (upd && emerg_mute_i && !clamp) |=> gain_code_ff ==
            8'($past(gain_code_ff) + step_counts($past(fast_down_increment)));
    endproperty
    a_emerg_step: assert property (p_emerg_step)
        else $error("Emergency step size wrong");

    property p_emerg_instant;
        (clk_en_i && emerg_mute_i && fast_down_rate == RATE_INSTANT) |=> gain_muted_o;
    endproperty
    a_emerg_instant: assert property (p_emerg_instant)
        else $error("Emergency instant mute missed");

    property p_no_overshoot;
        (upd && go_down) |=> gain_code_ff <= $past(goal);
    endproperty
    a_no_overshoot: assert property (p_no_overshoot)
        else $error("Down ramp passed its goal");

    property p_right_off;
        (clk_en_i && !mute_cfg_ff[RIGHT_EN_BIT]) |=> !right_mute_o;
    endproperty
    a_right_off: assert property (p_right_off)
        else $error("Right muted while disabled");

    property p_left_off;
        (clk_en_i && !mute_cfg_ff[LEFT_EN_BIT]) |=> !left_mute_o;
    endproperty
    a_left_off: assert property (p_left_off)
        else $error("Left muted while disabled");

    property p_coupled;
        (clk_en_i && mute_cfg_ff[COUPLE_BIT]) |=> left_mute_o == right_mute_o;
    endproperty
    a_coupled: assert property (p_coupled)
        else $error("Coupled channels muted apart");

endmodule
`default_nettype wire

// file: vrm_zero_run.sv
`timescale 1ns/1ps
`default_nettype none
module vrm_zero_run
    import vrm_pkg::*;
#(
    parameter int CNT_W = RUN_W
) (
    input  wire logic       mclk_i,
    input  wire logic       sys_rst_i,
    input  wire logic       clk_en_i,
    input  wire logic       sample_stb_i,  // One pulse per sample
    input  wire logic       sample_zero_i, // Sample value is zero
    input  wire logic       enable_i,      // Auto-mute allowed
    input  wire logic [2:0] run_sel_i,     // Run length select
    output logic            qualify_o      // Run reached, registered
);

    // ------------------------------------------------------------
    // Zero-run counter
    // ------------------------------------------------------------
    logic [CNT_W-1:0] cnt_ff;      // Zeros seen so far
    logic             qualify_ff;  // Run length reached
    logic [CNT_W-1:0] nxt_cnt;     // Count after this sample
    logic [CNT_W-1:0] limit;       // Selected run length

    assign nxt_cnt   = CNT_W'(cnt_ff + 1'b1);
    assign limit     = CNT_W'(zero_run_limit(run_sel_i));
    assign qualify_o = qualify_ff;

    // Count zeros; any non-zero sample or a disable restarts the run
    // run before qualify
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            cnt_ff     <= '0;
            qualify_ff <= 1'b0;
        end else if (clk_en_i) begin
            if (!enable_i || (sample_stb_i && !sample_zero_i)) begin
                cnt_ff     <= '0;
                qualify_ff <= 1'b0;
            end else if (sample_stb_i && !qualify_ff) begin
                // Counter holds once qualified, so it never wraps
                cnt_ff     <= nxt_cnt;
                qualify_ff <= (nxt_cnt >= limit);
            end
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (sys_rst_i);

    property p_run_reached;
        $rose(qualify_ff) |-> ($past(nxt_cnt) >= $past(limit)) && $past(sample_zero_i);
    endproperty
    a_run_reached: assert property (p_run_reached)
        else $error("Channel qualified before zero run completed");

endmodule
`default_nettype wire
